/* File: core/nmcc_coder.sv */
// Purpose: Serial symbol coder clocked by synchronised carrier edges.
// Assumes: Code and half period stay stable while a transfer runs.
// Notes:   Miller variants are coded at half-bit resolution.
`timescale 1ns/1ns
`default_nettype none
module nmcc_coder (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Carrier pin, asynchronous
  input wire logic carrier_in,
  // Coding setup
  input wire logic [2:0] code_in,
  input wire logic [7:0] half_in,
  input wire logic sub_en_in,
  input wire logic ext_in,
  // Bit stream
  input wire logic bit_in,
  input wire logic valid_in,
  output logic ready_out,
  // Coded line levels
  output logic int_level_out,
  output logic ext_level_out
);
  typedef struct packed {
    logic [2:0] car;   // Carrier synchroniser
    logic car_lvl;     // Agreed carrier level
    logic [7:0] hcnt;  // Carrier cycles within a half bit
    logic half;        // Second half of the bit
    logic bitv;        // Bit being sent
    logic prev;        // Previous bit, for Miller
    logic act;         // Bit in flight
    logic [2:0] scnt;  // Subcarrier divider
    logic sub;         // Subcarrier level
    logic ilvl;        // Internal modem level
    logic elvl;        // External modem level
  } nmcc_cod_type;

  nmcc_cod_type s, next_s;
  logic tick;
  logic bit_end;

  // Level for one half bit of the selected coding
  function automatic logic sym(input logic [2:0] c, input logic b,
                               input logic p, input logic h,
                               input logic sb, input logic se);
    logic v;
    v = b;
    case (c)
      nmcc_pkg::COD_MILLER, nmcc_pkg::COD_MOD_MILLER: begin
        // Zero after zero pauses early, one pauses late
        v = b ? !h : (p ? 1'b1 : h);
      end
      nmcc_pkg::COD_MANCH: begin
        v = (h ? !b : b) & (se ? sb : 1'b1);
      end
      nmcc_pkg::COD_BPSK: begin
        v = sb ^ b;
      end
      default: begin
        v = b;
      end
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Handshake: a new bit may follow the last one back to back
  assign tick = s.car[1] & s.car[2] & !s.car_lvl;
  assign bit_end = tick & s.act & s.half & (s.hcnt == half_in - 8'h01);
  assign ready_out = !s.act | bit_end;
  assign int_level_out = s.ilvl;
  assign ext_level_out = s.elvl;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic lv;
    lv = 1'b0;
    next_s = s;
    // Three flops; a change counts once the last two agree
    next_s.car = {s.car[1:0], carrier_in};
    if (s.car[1] == s.car[2]) begin
      next_s.car_lvl = s.car[2];
    end
    if (tick) begin
      // Subcarrier runs continuously so BPSK phase stays coherent
      next_s.scnt = s.scnt + 3'h1;
      if (s.scnt == nmcc_pkg::SUB_HALF_LAST) begin
        next_s.sub = !s.sub;
      end
      if (s.act) begin
        next_s.hcnt = s.hcnt + 8'h01;
        if (s.hcnt == half_in - 8'h01) begin
          next_s.hcnt = 8'h00;
          next_s.half = !s.half;
          if (s.half) begin
            next_s.act = 1'b0;
            next_s.prev = s.bitv;
          end
        end
      end
    end
    if (valid_in && ready_out) begin
      next_s.act = 1'b1;
      next_s.bitv = bit_in;
      next_s.half = 1'b0;
      next_s.hcnt = 8'h00;
    end
    // Idle line: carrier unmodulated for Miller, no load otherwise
    if (next_s.act) begin
      lv = sym(code_in, next_s.bitv, next_s.prev, next_s.half,
               next_s.sub, sub_en_in);
    end else begin
      lv = (code_in == nmcc_pkg::COD_MILLER) ||
           (code_in == nmcc_pkg::COD_MOD_MILLER);
    end
    next_s.ilvl = ext_in ? 1'b0 : lv;
    next_s.elvl = ext_in ? lv : 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Path split between internal and external modem
  modem_split_a: assert property (@(posedge clk_in)
    disable iff (!rst_b_in) ext_in |-> ##1 !int_level_out)
    else $error("internal modem driven while external selected");
  bit_take_a: assert property (@(posedge clk_in)
    disable iff (!rst_b_in) $rose(s.act) |-> $past(valid_in))
    else $error("bit started without valid");
endmodule
`default_nettype wire

/* File: core/nmcc_ctrl.sv */
// Purpose: Role sequencing and coding selection for the contactless unit.
// Assumes: Field detect and carrier are asynchronous pins.
// Notes:   Framer reports transaction end on TXN_DONE_IN.
//
// Contract
// - Start up as target, own field off
// - Field level detector on in target role
// - Initiator role only on explicit request
// - Carrier on after quiet field interval
// - Initialise for selected mode once carrier on
// - Transactions never overlap or interrupt
// - Rate held constant during a transfer
// - Type A card: Miller in, Manchester/BPSK out
// - Alternate card: 212/424 Manchester, no subcarrier
// - Framing and error check per protocol
// - Internal modem serves modes up to 424
// - External modem pins for rates to 3.39M; the one external rate here has 8 carrier cycles per bit
// - Active peer: Miller 106, Manchester above
`timescale 1ns/1ns
`default_nettype none
module nmcc_ctrl #(
  parameter int FIELD_CHECK_CYCLES = nmcc_pkg::FIELD_CHECK_CYCLES
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_B_IN,
  // Firmware selection
  input wire logic INITIATOR_REQ_IN,
  input wire logic [2:0] MODE_SEL_IN,
  input wire logic [1:0] RATE_SEL_IN,
  output logic SEL_ERR_OUT,
  // Transaction control
  input wire logic TXN_START_IN,
  input wire logic TXN_DONE_IN,
  output logic TXN_BUSY_OUT,
  output logic INIT_START_OUT,
  // RF front end
  input wire logic FIELD_DET_IN,
  input wire logic CARRIER_IN,
  output logic RF_FIELD_ON_OUT,
  output logic LEVEL_DET_EN_OUT,
  output logic INITIATOR_OUT,
  // Active coding setup
  output logic [2:0] TX_CODING_OUT,
  output logic [2:0] RX_CODING_OUT,
  output logic SUBCARRIER_OUT,
  output logic [7:0] HALF_BIT_OUT,
  output logic [1:0] FRAME_KIND_OUT,
  output logic EXT_MODEM_SEL_OUT,
  // Transmit bit stream
  input wire logic TX_BIT_IN,
  input wire logic TX_VALID_IN,
  output logic TX_READY_OUT,
  output logic TX_LEVEL_OUT,
  output logic EXT_MODEM_TX_OUTPUT_OUT
);
  localparam int CW = $clog2(FIELD_CHECK_CYCLES + 1);

  // Refuse a quiet interval that the counter cannot serve
  if (FIELD_CHECK_CYCLES < 1) begin : g_chk
    $error("FIELD_CHECK_CYCLES must be at least 1");
  end

  typedef struct packed {
    nmcc_pkg::nmcc_state_type st; // Role sequencer
    logic [CW-1:0] cnt;           // Quiet field cycles seen
    logic [2:0] fd;               // Field detect synchroniser
    logic fd_lvl;                 // Agreed field level
    logic busy;                   // Transaction in progress
    logic init;                   // Initialisation pulse
    logic err;                    // Last selection refused
    logic [2:0] mode;             // Applied scheme
    logic [1:0] rate;             // Applied rate
    logic [2:0] txc;              // Transmit coding
    logic [2:0] rxc;              // Receive coding
    logic sub;                    // Subcarrier on answer
    logic [7:0] half;             // Half bit in carrier cycles
    logic [1:0] frm;              // Framing kind
  } nmcc_ctrl_type;

  nmcc_ctrl_type s, next_s;

  // Combination of scheme and rate that the coder can serve
  function automatic logic sel_ok(input logic [2:0] m, input logic [1:0] r);
    logic ok;
    ok = (m <= nmcc_pkg::MODE_READER);
    if (m == nmcc_pkg::MODE_CARD_ALT && r != nmcc_pkg::RATE_212 &&
        r != nmcc_pkg::RATE_424) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // Coding word {tx, rx, subcarrier} for scheme, rate and role
  function automatic logic [6:0] codes(input logic [2:0] m,
                                       input logic [1:0] r,
                                       input logic ini);
    logic [6:0] c;
    logic low;
    low = (r == nmcc_pkg::RATE_106);
    c = {nmcc_pkg::COD_MANCH, nmcc_pkg::COD_MOD_MILLER, low};
    case (m)
      nmcc_pkg::MODE_CARD_A: begin
        // Answer on carrier/16 subcarrier at every rate
        c = {low ? nmcc_pkg::COD_MANCH : nmcc_pkg::COD_BPSK,
             nmcc_pkg::COD_MOD_MILLER, 1'b1};
      end
      nmcc_pkg::MODE_CARD_ALT: begin
        c = {nmcc_pkg::COD_MANCH, nmcc_pkg::COD_MANCH, 1'b0};
      end
      nmcc_pkg::MODE_PEER_ACT: begin
        c = low ? {nmcc_pkg::COD_MILLER, nmcc_pkg::COD_MILLER, 1'b0}
                : {nmcc_pkg::COD_MANCH, nmcc_pkg::COD_MANCH, 1'b0};
      end
      nmcc_pkg::MODE_PEER_PAS, nmcc_pkg::MODE_READER: begin
        // Poller sends Miller, listener answers Manchester
        if (ini || m == nmcc_pkg::MODE_READER) begin
          c = {nmcc_pkg::COD_MOD_MILLER, nmcc_pkg::COD_MANCH, 1'b0};
        end else begin
          c = {nmcc_pkg::COD_MANCH, nmcc_pkg::COD_MOD_MILLER, low};
        end
      end
      default: begin
        c = {nmcc_pkg::COD_NRZ, nmcc_pkg::COD_NRZ, 1'b0};
      end
    endcase
    return c;
  endfunction

  // Half bit length for a rate code
  function automatic logic [7:0] half_of(input logic [1:0] r);
    logic [7:0] h;
    case (r)
      nmcc_pkg::RATE_106: h = nmcc_pkg::HALF_106;
      nmcc_pkg::RATE_212: h = nmcc_pkg::HALF_212;
      nmcc_pkg::RATE_424: h = nmcc_pkg::HALF_424;
      default: h = nmcc_pkg::HALF_EXT;
    endcase
    return h;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from state flops
  assign RF_FIELD_ON_OUT = (s.st == nmcc_pkg::ST_INITIATOR);
  assign INITIATOR_OUT = (s.st == nmcc_pkg::ST_INITIATOR);
  // Own carrier would trip the detector, so it is off in initiator role
  assign LEVEL_DET_EN_OUT = (s.st != nmcc_pkg::ST_INITIATOR);
  assign TXN_BUSY_OUT = s.busy;
  assign INIT_START_OUT = s.init;
  assign SEL_ERR_OUT = s.err;
  assign TX_CODING_OUT = s.txc;
  assign RX_CODING_OUT = s.rxc;
  assign SUBCARRIER_OUT = s.sub;
  assign HALF_BIT_OUT = s.half;
  assign FRAME_KIND_OUT = s.frm;
  // Internal modem covers up to 424; faster rates leave by the pins
  assign EXT_MODEM_SEL_OUT = (s.rate == nmcc_pkg::RATE_EXT);

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic ini;
    logic [6:0] c;
    ini = 1'b0;
    c = '0;
    next_s = s;
    next_s.init = 1'b0;
    next_s.fd = {s.fd[1:0], FIELD_DET_IN};
    if (s.fd[1] == s.fd[2]) begin
      next_s.fd_lvl = s.fd[2];
    end
    // Framer marks the end of the whole transaction
    if (TXN_DONE_IN) begin
      next_s.busy = 1'b0;
    end
    case (s.st)
      nmcc_pkg::ST_TARGET: begin
        if (INITIATOR_REQ_IN && !s.busy) begin
          next_s.st = nmcc_pkg::ST_FIELD_CHECK;
          next_s.cnt = '0;
        end else if (TXN_START_IN && !s.busy) begin
          next_s.busy = 1'b1;
        end
      end
      nmcc_pkg::ST_FIELD_CHECK: begin
        if (!INITIATOR_REQ_IN) begin
          next_s.st = nmcc_pkg::ST_TARGET;
        end else if (s.fd_lvl) begin
          // Someone else's field: restart the quiet interval
          next_s.cnt = '0;
        end else if (s.cnt == CW'(FIELD_CHECK_CYCLES - 1)) begin
          next_s.st = nmcc_pkg::ST_INITIATOR;
          next_s.init = 1'b1;
          next_s.busy = 1'b1;
        end else begin
          next_s.cnt = s.cnt + CW'(1);
        end
      end
      nmcc_pkg::ST_INITIATOR: begin
        if (!INITIATOR_REQ_IN && !s.busy) begin
          next_s.st = nmcc_pkg::ST_TARGET;
        end else if (TXN_START_IN && !s.busy) begin
          next_s.busy = 1'b1;
        end
      end
      default: begin
        next_s.st = nmcc_pkg::ST_TARGET;
      end
    endcase
    // Apply selection only while idle; it then holds through the transfer
    if (!s.busy) begin
      if (sel_ok(MODE_SEL_IN, RATE_SEL_IN)) begin
        ini = (next_s.st == nmcc_pkg::ST_INITIATOR);
        c = codes(MODE_SEL_IN, RATE_SEL_IN, ini);
        next_s.err = 1'b0;
        next_s.mode = MODE_SEL_IN;
        next_s.rate = RATE_SEL_IN;
        next_s.txc = c[6:4];
        next_s.rxc = c[3:1];
        next_s.sub = c[0];
        next_s.half = half_of(RATE_SEL_IN);
        // Byte parity only on the 106 kbit/s Miller family
        next_s.frm = (RATE_SEL_IN == nmcc_pkg::RATE_106)
                     ? nmcc_pkg::FRM_PARITY_CRC
                     : nmcc_pkg::FRM_PREAMBLE_CRC;
      end else begin
        next_s.err = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; reset lands in target role, field off
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      s <= '0;
      s.mode <= nmcc_pkg::MODE_NONE; // NRZ reset codes belong to no scheme
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Symbol coder
  nmcc_coder u_coder (
    .clk_in(SYS_CLK_IN),
    .rst_b_in(RST_B_IN),
    .carrier_in(CARRIER_IN),
    .code_in(s.txc),
    .half_in(s.half),
    .sub_en_in(s.sub),
    .ext_in(EXT_MODEM_SEL_OUT),
    .bit_in(TX_BIT_IN),
    .valid_in(TX_VALID_IN),
    .ready_out(TX_READY_OUT),
    .int_level_out(TX_LEVEL_OUT),
    .ext_level_out(EXT_MODEM_TX_OUTPUT_OUT)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence quiet_wait_s;
    !s.fd_lvl && s.st == nmcc_pkg::ST_FIELD_CHECK &&
      s.cnt == CW'(FIELD_CHECK_CYCLES - 1);
  endsequence
  sequence carrier_up_s;
    $rose(RF_FIELD_ON_OUT) && INIT_START_OUT && TXN_BUSY_OUT;
  endsequence

  target_idle_a: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RST_B_IN) s.st == nmcc_pkg::ST_TARGET |->
      !RF_FIELD_ON_OUT && !INITIATOR_OUT)
    else $error("field on in target role");
  level_det_a: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RST_B_IN) !INITIATOR_OUT |-> LEVEL_DET_EN_OUT)
    else $error("level detector off in target role");
  init_request_a: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RST_B_IN) $rose(INITIATOR_OUT) |->
      $past(INITIATOR_REQ_IN))
    else $error("initiator entered without request");
  field_quiet_a: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RST_B_IN) $rose(RF_FIELD_ON_OUT) |->
      $past(s.cnt) == CW'(FIELD_CHECK_CYCLES - 1) && !$past(s.fd_lvl))
    else $error("carrier on before quiet interval");
  init_start_a: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RST_B_IN) quiet_wait_s ##0 INITIATOR_REQ_IN |=>
      carrier_up_s ##1 !INIT_START_OUT)
    else $error("initialisation not started with carrier");
  no_overlap_a: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RST_B_IN) TXN_BUSY_OUT && !TXN_DONE_IN |=>
      TXN_BUSY_OUT && !INIT_START_OUT)
    else $error("transaction interrupted");
  rate_hold_a: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RST_B_IN) TXN_BUSY_OUT |=>
      $stable(HALF_BIT_OUT) && $stable(TX_CODING_OUT))
    else $error("rate changed during transfer");
  card_a_code_a: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RST_B_IN) s.mode == nmcc_pkg::MODE_CARD_A && !s.err |->
      SUBCARRIER_OUT && RX_CODING_OUT == nmcc_pkg::COD_MOD_MILLER &&
      TX_CODING_OUT == ((s.rate == nmcc_pkg::RATE_106) ?
        nmcc_pkg::COD_MANCH : nmcc_pkg::COD_BPSK))
    else $error("type A card coding wrong");
  alt_rate_a: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RST_B_IN) s.mode == nmcc_pkg::MODE_CARD_ALT |->
      (s.rate == nmcc_pkg::RATE_212 || s.rate == nmcc_pkg::RATE_424) &&
      !SUBCARRIER_OUT)
    else $error("alternate card at unsupported rate");
  peer_code_a: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RST_B_IN) s.mode == nmcc_pkg::MODE_PEER_ACT |->
      TX_CODING_OUT == RX_CODING_OUT)
    else $error("active peer coding differs by direction");
endmodule
`default_nettype wire

/* File: core/nmcc_pkg.sv */
// Purpose: Shared constants and types of the NFC mode and coding control.
// Assumes: 125 MHz system clock; carrier arrives as a square wave pin.
// Notes:   Coding codes are shared by both modules; rate and framing codes are used by nmcc_ctrl only.
package nmcc_pkg;
  // Operating scheme selected by firmware
  localparam logic [2:0] MODE_CARD_A = 3'h0;
  localparam logic [2:0] MODE_CARD_ALT = 3'h1;
  localparam logic [2:0] MODE_PEER_ACT = 3'h2;
  localparam logic [2:0] MODE_PEER_PAS = 3'h3;
  localparam logic [2:0] MODE_READER = 3'h4;
  localparam logic [2:0] MODE_NONE = 3'h7; // Reset: no scheme applied yet
  // Bit rate codes; the last one goes through the external modem
  localparam logic [1:0] RATE_106 = 2'h0;
  localparam logic [1:0] RATE_212 = 2'h1;
  localparam logic [1:0] RATE_424 = 2'h2;
  localparam logic [1:0] RATE_EXT = 2'h3;
  // Bit coding codes
  localparam logic [2:0] COD_NRZ = 3'h0;
  localparam logic [2:0] COD_MILLER = 3'h1;
  localparam logic [2:0] COD_MOD_MILLER = 3'h2;
  localparam logic [2:0] COD_MANCH = 3'h3;
  localparam logic [2:0] COD_BPSK = 3'h4;
  // Framing kinds handed to the framer
  localparam logic [1:0] FRM_PARITY_CRC = 2'h0;
  localparam logic [1:0] FRM_PREAMBLE_CRC = 2'h1;
  // Half bit periods in carrier cycles (full bit 128, 64, 32, 8)
  localparam logic [7:0] HALF_106 = 8'h40;
  localparam logic [7:0] HALF_212 = 8'h20;
  localparam logic [7:0] HALF_424 = 8'h10;
  localparam logic [7:0] HALF_EXT = 8'h04;
  // Subcarrier is carrier/16, so it toggles every 8 carrier cycles
  localparam logic [2:0] SUB_HALF_LAST = 3'h7;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int FIELD_CHECK_US = 1000;
  localparam int FIELD_CHECK_CYCLES =
    (FIELD_CHECK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Role sequencer states
  typedef enum logic [1:0] {
    ST_TARGET,
    ST_FIELD_CHECK,
    ST_INITIATOR
  } nmcc_state_type;
endpackage

/* File: sim/nmcc_rf_model.sv */
// Purpose: Far side model: external carrier and RF level detector pins.
// Assumes: Carrier runs free at 13.89 MHz, close to the real carrier.
// Notes:   Field detect edges are skewed off the system clock.
`timescale 1ns/1ns
`default_nettype none
module nmcc_rf_model (
  // Control from bench
  input wire logic ext_field_in,
  // Pins toward the design
  output logic carrier_out,
  output logic field_det_out
);
  // Carrier square wave, never stops; its 72 ns period is nine clock periods, so its phase is fixed against the clock
  initial begin
    carrier_out = 1'b0;
    forever #36 carrier_out = ~carrier_out;
  end
  // Detector follows the field with an analog lag, not clock aligned
  always @(ext_field_in) begin
    field_det_out <= #3 ext_field_in;
  end
  initial field_det_out = 1'b1;
endmodule
`default_nettype wire

/* File: sim/test_nmcc_ctrl.sv */
// Purpose: Self-checking bench of the role sequencer and coding select.
// Assumes: Field check count shortened to 20 cycles.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/1ns
`default_nettype none
module test_nmcc_ctrl;
  localparam int CHK = 20; // Shortened quiet field interval
  typedef struct packed {
    logic [2:0] mode; logic [1:0] rate; logic [2:0] tx; logic [2:0] rx;
    logic [1:0] sub; logic [7:0] half;
  } nmcc_case_type;
  logic clk = 1'b0, rst_b = 1'b0, req = 1'b0, start = 1'b0, done = 1'b0;
  logic [2:0] mode = 3'h4;
  logic [1:0] rate = 2'h0;
  logic bit_v = 1'b0, valid = 1'b0, ext_field = 1'b1;
  logic err, busy, init_st, fdet, car, rf_on, lvl_en, ini, sub, esel;
  logic ready, lvl, elvl;
  logic [2:0] txc, rxc;
  logic [7:0] half;
  logic [1:0] frm;
  int failures = 0, n_compared = 0;
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  nmcc_ctrl #(.FIELD_CHECK_CYCLES(CHK)) i_nmcc_ctrl (
    .SYS_CLK_IN(clk), .RST_B_IN(rst_b), .INITIATOR_REQ_IN(req),
    .MODE_SEL_IN(mode), .RATE_SEL_IN(rate), .SEL_ERR_OUT(err),
    .TXN_START_IN(start), .TXN_DONE_IN(done), .TXN_BUSY_OUT(busy),
    .INIT_START_OUT(init_st), .FIELD_DET_IN(fdet), .CARRIER_IN(car),
    .RF_FIELD_ON_OUT(rf_on), .LEVEL_DET_EN_OUT(lvl_en),
    .INITIATOR_OUT(ini), .TX_CODING_OUT(txc), .RX_CODING_OUT(rxc),
    .SUBCARRIER_OUT(sub), .HALF_BIT_OUT(half), .FRAME_KIND_OUT(frm),
    .EXT_MODEM_SEL_OUT(esel), .TX_BIT_IN(bit_v), .TX_VALID_IN(valid),
    .TX_READY_OUT(ready), .TX_LEVEL_OUT(lvl),
    .EXT_MODEM_TX_OUTPUT_OUT(elvl));
  nmcc_rf_model i_nmcc_rf_model (
    .ext_field_in(ext_field), .carrier_out(car), .field_det_out(fdet));
  ////////////////////////////////////////////////////////////////////////
  // Closing report, also reached from the exhausted ready wait in t_stream
  task automatic tally_and_finish();
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One comparison, four-state exact
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  // Step to just after the next rising edge
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  // Apply a selection while idle and let it land
  task automatic select(input logic [2:0] m, input logic [1:0] r);
    mode = m;
    rate = r;
    step(3);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Power-up role: target, own field off, detector on
  task automatic t_startup();
    step(30);
    check({7'h0, rf_on}, 8'h0, "field on");
    check({7'h0, ini}, 8'h0, "initiator");
    check({7'h0, lvl_en}, 8'h1, "detector");
    check({7'h0, init_st}, 8'h0, "init");
    check({7'h0, lvl}, 8'h1, "miller idle");
  endtask
  // Coding table for the card and active peer schemes
  task automatic t_coding();
    nmcc_case_type tc [8];
    tc[0] = {3'h0, 2'h0, nmcc_pkg::COD_MANCH, nmcc_pkg::COD_MOD_MILLER,
             2'h1, nmcc_pkg::HALF_106};
    tc[1] = {3'h0, 2'h1, nmcc_pkg::COD_BPSK, nmcc_pkg::COD_MOD_MILLER,
             2'h1, nmcc_pkg::HALF_212};
    tc[2] = {3'h0, 2'h2, nmcc_pkg::COD_BPSK, nmcc_pkg::COD_MOD_MILLER,
             2'h1, nmcc_pkg::HALF_424};
    tc[3] = {3'h1, 2'h1, nmcc_pkg::COD_MANCH, nmcc_pkg::COD_MANCH,
             2'h0, nmcc_pkg::HALF_212};
    tc[4] = {3'h1, 2'h2, nmcc_pkg::COD_MANCH, nmcc_pkg::COD_MANCH,
             2'h0, nmcc_pkg::HALF_424};
    tc[5] = {3'h2, 2'h0, nmcc_pkg::COD_MILLER, nmcc_pkg::COD_MILLER,
             2'h2, nmcc_pkg::HALF_106};
    tc[6] = {3'h2, 2'h1, nmcc_pkg::COD_MANCH, nmcc_pkg::COD_MANCH,
             2'h2, nmcc_pkg::HALF_212};
    tc[7] = {3'h2, 2'h2, nmcc_pkg::COD_MANCH, nmcc_pkg::COD_MANCH,
             2'h2, nmcc_pkg::HALF_424};
    for (int i = 0; i < 8; i++) begin
      select(tc[i].mode, tc[i].rate);
      check({5'h0, txc}, {5'h0, tc[i].tx}, "tx code");
      check({5'h0, rxc}, {5'h0, tc[i].rx}, "rx code");
      check(half, tc[i].half, "half bit");
      check({7'h0, err}, 8'h0, "sel err");
      if (tc[i].sub != 2'h2) begin
        check({7'h0, sub}, {7'h0, tc[i].sub[0]}, "subcarrier");
      end
    end
    // Alternate scheme has no 106 rate: refused, setup kept
    select(3'h1, 2'h0);
    check({7'h0, err}, 8'h1, "alt 106");
    check(half, nmcc_pkg::HALF_424, "kept half");
    select(3'h1, 2'h3);
    check({7'h0, err}, 8'h1, "alt ext");
    select(3'h3, 2'h0);
    check({5'h0, txc}, {5'h0, nmcc_pkg::COD_MANCH}, "pas tx");
    check({7'h0, sub}, 8'h1, "pas sub");
    select(3'h5, 2'h1);
    check({7'h0, err}, 8'h1, "bad mode");
    select(3'h1, 2'h1);
    check({6'h0, frm}, {6'h0, nmcc_pkg::FRM_PREAMBLE_CRC}, "frame");
    select(3'h0, 2'h0);
    check({6'h0, frm}, {6'h0, nmcc_pkg::FRM_PARITY_CRC}, "frame");
    select(3'h4, 2'h3);
    check({7'h0, esel}, 8'h1, "ext sel");
    check(half, nmcc_pkg::HALF_EXT, "ext half");
    check({7'h0, elvl}, 8'h1, "ext idle");
    check({7'h0, lvl}, 8'h0, "int quiet");
  endtask
  // One Manchester bit 1 at 424 with no subcarrier: high, then low
  task automatic t_stream();
    int n;
    select(3'h1, 2'h2);
    bit_v = 1'b1;
    valid = 1'b1;
    n = 0;
    @(negedge clk);
    while (ready !== 1'b1) begin
      n++;
      if (n > 2000) begin
        check(8'h0, 8'h1, "ready timeout");
        tally_and_finish();
      end
      @(negedge clk);
    end
    step(1);
    valid = 1'b0;
    // Half bit is 16 carrier cycles, about 144 system cycles
    step(80);
    check({7'h0, lvl}, 8'h1, "first half");
    check({7'h0, elvl}, 8'h0, "ext pin idle");
    step(144);
    check({7'h0, lvl}, 8'h0, "second half");
  endtask
  // Initiator start-up guarded by the quiet field interval
  task automatic t_initiator();
    int n;
    select(3'h4, 2'h0);
    req = 1'b1;
    step(4 * CHK);
    check({7'h0, rf_on}, 8'h0, "field seen");
    ext_field = 1'b0;
    n = 0;
    while (rf_on !== 1'b1 && n < CHK + 12) begin
      step(1);
      n++;
    end
    check({7'h0, n >= CHK && n < CHK + 12}, 8'h1, "quiet time");
    check({7'h0, init_st}, 8'h1, "init pulse");
    check({7'h0, busy}, 8'h1, "busy");
    check({7'h0, lvl_en}, 8'h0, "detector");
    // Rate change and second start inside the transaction
    rate = 2'h2;
    start = 1'b1;
    step(1);
    start = 1'b0;
    check({7'h0, init_st}, 8'h0, "pulse end");
    step(3);
    check(half, nmcc_pkg::HALF_106, "rate held");
    done = 1'b1;
    step(1);
    done = 1'b0;
    step(2);
    check({7'h0, busy}, 8'h0, "not busy");
    check(half, nmcc_pkg::HALF_424, "rate taken");
    req = 1'b0;
    ext_field = 1'b1;
    step(3);
    check({7'h0, rf_on}, 8'h0, "back target");
    check({7'h0, lvl_en}, 8'h1, "detector on");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence: four-cycle reset, then the scenarios
  initial begin
    step(4);
    rst_b = 1'b1;
    t_startup();
    t_coding();
    t_stream();
    t_initiator();
    tally_and_finish();
  end
endmodule
`default_nettype wire
